/* pkg/txbcu_defines.vh */
// register map, command word fields and reset values of the transmit buffer command unpacker
`ifndef TXBCU_DEFINES_VH
`define TXBCU_DEFINES_VH

// register byte offsets on the apb slave
`define TXBCU_OFS_DATA_PORT     8'h00
`define TXBCU_OFS_STATUS        8'h04
`define TXBCU_OFS_CTRL          8'h08
`define TXBCU_OFS_INFO          8'h0C

// status register bits, write one to clear
`define TXBCU_STS_TX_ERR        0
`define TXBCU_STS_BUF_LOADED    1

// control register bits and reset value
`define TXBCU_CTRL_ENABLE       0
`define TXBCU_CTRL_ABORT        1
`define TXBCU_CTRL_RESET        2'h1

// first command word fields
`define TXBCU_A_LOAD_NOTIFY     31
`define TXBCU_A_ALIGN_HI        25
`define TXBCU_A_ALIGN_LO        24
`define TXBCU_A_OFFSET_HI       20
`define TXBCU_A_OFFSET_LO       16
`define TXBCU_A_FIRST_SEG       13
`define TXBCU_A_LAST_SEG        12
`define TXBCU_A_SIZE_HI         10
`define TXBCU_A_SIZE_LO         0

// second command word fields
`define TXBCU_B_TAG_HI          31
`define TXBCU_B_TAG_LO          16
`define TXBCU_B_CRC_DIS         13
`define TXBCU_B_PAD_DIS         12
`define TXBCU_B_LEN_HI          10
`define TXBCU_B_LEN_LO          0

// end alignment codes and their byte counts
`define TXBCU_ALIGN_4           2'h0
`define TXBCU_ALIGN_16          2'h1
`define TXBCU_ALIGN_32          2'h2
`define TXBCU_BYTES_4           12'h004
`define TXBCU_BYTES_16          12'h010
`define TXBCU_BYTES_32          12'h020

`endif

/* src/txbcu_top.v */
// transmit buffer command unpacker: apb data port, command parsing, byte lane enables, length checks
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "txbcu_defines.vh"

module txbcu_top (
	input  wire        CORE_CLK,
	input  wire        RST_B,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [7:0]  PADDR,
	input  wire [31:0] PWDATA,
	output wire [31:0] PRDATA,
	output wire        PREADY,
	output wire        PSLVERR,
	output wire [31:0] MAC_DATA,
	output wire [3:0]  MAC_BYTE_EN,
	output wire        MAC_LAST,
	output wire        MAC_VALID,
	input  wire        MAC_READY,
	output wire        MAC_PKT_END,
	output wire [15:0] MAC_TAG,
	output wire [10:0] MAC_LEN,
	output wire        MAC_ADD_CRC,
	output wire        MAC_ADD_PAD,
	output wire        MAC_LEN_ERR,
	output wire        TRANSMIT_ERROR_FLAG,
	output wire        BUFFER_LOADED_FLAG
);

	localparam ST_CMDA = 2'h0;
	localparam ST_CMDB = 2'h1;
	localparam ST_BODY = 2'h2;

	// rounds a byte count up to a multiple of a power of two
	function [11:0] round_up;
		input [11:0] val;
		input [11:0] unit;
		begin
			round_up = (val + unit - 12'h001) & ~(unit - 12'h001);
		end
	endfunction

	// byte enables from a first lane to a last lane
	function [3:0] lane_mask;
		input [1:0] lo;
		input [1:0] hi;
		integer     i;
		begin
			lane_mask = 4'h0;
			for (i = 0; i < 4; i = i + 1) begin
				lane_mask[i] = (i[1:0] >= lo) && (i[1:0] <= hi);
			end
		end
	endfunction

	// bus state
	reg  [1:0]  state_r, state_nxt;
	reg  [31:0] cmda_r;
	reg  [31:0] pkt_cmdb_r;
	reg         pkt_open_r;
	reg  [11:0] acc_r;
	reg  [11:0] idx_r;
	reg         err_r, loaded_r;
	reg  [1:0]  ctrl_r;
	reg  [31:0] prdata_r;
	reg  [31:0] out_data_r;
	reg  [3:0]  out_be_r;
	reg         out_last_r, out_valid_r;
	reg         pkt_end_r, len_err_r, add_crc_r, add_pad_r;
	reg  [15:0] tag_r;
	reg  [10:0] len_r;

	// decode of the apb access
	wire        setup     = PSEL && !PENABLE;
	wire        access    = PSEL && PENABLE;
	wire        hit_data  = (PADDR == `TXBCU_OFS_DATA_PORT);
	wire        hit_sts   = (PADDR == `TXBCU_OFS_STATUS);
	wire        hit_ctrl  = (PADDR == `TXBCU_OFS_CTRL);
	wire        hit_info  = (PADDR == `TXBCU_OFS_INFO);
	wire        mapped    = hit_data || hit_sts || hit_ctrl || hit_info;
	wire        enabled   = ctrl_r[`TXBCU_CTRL_ENABLE];
	wire        port_ok   = hit_data && PWRITE && enabled;
	wire        bad_acc   = !mapped || (hit_data && (!PWRITE || !enabled));

	// fields of the current buffer
	wire [4:0]  offset    = cmda_r[`TXBCU_A_OFFSET_HI:`TXBCU_A_OFFSET_LO];
	wire [1:0]  align     = cmda_r[`TXBCU_A_ALIGN_HI:`TXBCU_A_ALIGN_LO];
	wire [10:0] bsize     = cmda_r[`TXBCU_A_SIZE_HI:`TXBCU_A_SIZE_LO];
	wire        first_seg = cmda_r[`TXBCU_A_FIRST_SEG];
	wire        last_seg  = cmda_r[`TXBCU_A_LAST_SEG];
	wire [11:0] span      = {7'h00, offset} + {1'b0, bsize};
	wire [11:0] skip      = {9'h000, offset[4:2]};
	// an empty buffer forwards no word even when its start is not word aligned
	wire [11:0] ndata     = (bsize == 11'h000) ? 12'h000 :
	                        ((span - {7'h00, offset[4:2], 2'h0} + 12'h003) >> 2);

	// end alignment in bytes; the spare code behaves as word alignment
	reg  [11:0] align_bytes;
	always @* begin
		case (align)
			`TXBCU_ALIGN_16: align_bytes = `TXBCU_BYTES_16;
			`TXBCU_ALIGN_32: align_bytes = `TXBCU_BYTES_32;
			default:         align_bytes = `TXBCU_BYTES_4;
		endcase
	end

	// whole words of the buffer body, filler included
	wire [11:0] total     = round_up(span, align_bytes) >> 2;
	wire [11:0] data_end  = skip + ndata;
	wire        in_data   = (idx_r >= skip) && (idx_r < data_end);
	wire        is_first  = (idx_r == skip);
	wire        is_final  = (idx_r == data_end - 12'h001);
	wire [1:0]  end_lane  = span[1:0] - 2'h1;

	// data words of the body wait while the output word is held by the mac; filler words do not
	wire        out_free  = !out_valid_r || MAC_READY;
	wire        stall     = port_ok && (state_r == ST_BODY) && in_data && !out_free;
	wire        port_wr   = access && port_ok && !stall;

	assign PREADY  = !stall;
	assign PSLVERR = access && bad_acc;
	assign PRDATA  = prdata_r;

	// buffer completes on its last body word, or at once when it has none
	wire        cmdb_wr   = port_wr && (state_r == ST_CMDB);
	wire        body_wr   = port_wr && (state_r == ST_BODY);
	wire        buf_done  = (cmdb_wr && (total == 12'h000)) ||
	                        (body_wr && (idx_r == total - 12'h001));
	wire        b_differs = cmdb_wr && pkt_open_r && !first_seg &&
	                        (PWDATA != pkt_cmdb_r);
	// a buffer may close on its own word B, so the new word and sum are used at once
	wire        pkt_start = first_seg || !pkt_open_r;
	wire [31:0] pkt_b     = (cmdb_wr && pkt_start) ? PWDATA : pkt_cmdb_r;
	wire [11:0] acc_sum   = !cmdb_wr ? acc_r :
	                        (pkt_start ? {1'b0, bsize} : acc_r + {1'b0, bsize});
	wire        len_bad   = buf_done && last_seg &&
	                        (acc_sum != {1'b0, pkt_b[`TXBCU_B_LEN_HI:`TXBCU_B_LEN_LO]});

	// status register write one to clear
	wire        sts_wr    = access && PWRITE && hit_sts;
	wire        clr_err   = sts_wr && PWDATA[`TXBCU_STS_TX_ERR];
	wire        clr_load  = sts_wr && PWDATA[`TXBCU_STS_BUF_LOADED];
	wire        abort     = access && PWRITE && hit_ctrl && PWDATA[`TXBCU_CTRL_ABORT];

	// word sequencing through the two command words and the body
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_CMDA: begin
				if (port_wr) begin
					state_nxt = ST_CMDB;
				end
			end
			ST_CMDB: begin
				if (port_wr) begin
					state_nxt = buf_done ? ST_CMDA : ST_BODY;
				end
			end
			ST_BODY: begin
				if (buf_done) begin
					state_nxt = ST_CMDA;
				end
			end
			default: state_nxt = ST_CMDA;
		endcase
		if (abort) begin
			state_nxt = ST_CMDA;
		end
	end

	// command words are latched here and never forwarded
	always @(posedge CORE_CLK) begin
		if (!RST_B) begin
			state_r    <= ST_CMDA;
			cmda_r     <= 32'h00000000;
			pkt_cmdb_r <= 32'h00000000;
			pkt_open_r <= 1'b0;
			acc_r      <= 12'h000;
			idx_r      <= 12'h000;
		end else begin
			state_r <= state_nxt;
			if (port_wr && state_r == ST_CMDA) begin
				cmda_r <= PWDATA;
			end
			if (cmdb_wr) begin
				idx_r      <= 12'h000;
				acc_r      <= acc_sum;
				pkt_open_r <= 1'b1;
				// the packet's word B is kept from its first segment
				if (pkt_start) begin
					pkt_cmdb_r <= PWDATA;
				end
			end else if (body_wr) begin
				idx_r <= idx_r + 12'h001;
			end
			if (buf_done && last_seg) begin
				pkt_open_r <= 1'b0;
			end
			if (abort) begin
				pkt_open_r <= 1'b0;
			end
		end
	end

	// output word register toward the mac transmit path
	always @(posedge CORE_CLK) begin
		if (!RST_B) begin
			out_data_r  <= 32'h00000000;
			out_be_r    <= 4'h0;
			out_last_r  <= 1'b0;
			out_valid_r <= 1'b0;
		end else begin
			if (body_wr && in_data) begin
				out_data_r  <= PWDATA;
				// lanes outside the buffer bytes are not enabled
				out_be_r    <= lane_mask(is_first ? offset[1:0] : 2'h0,
				                         is_final ? end_lane : 2'h3);
				out_last_r  <= is_final && last_seg;
				out_valid_r <= 1'b1;
			end else if (MAC_READY) begin
				out_valid_r <= 1'b0;
			end
		end
	end

	// packet close: commit pulse, tag and frame options for the mac
	always @(posedge CORE_CLK) begin
		if (!RST_B) begin
			pkt_end_r <= 1'b0;
			len_err_r <= 1'b0;
			tag_r     <= 16'h0000;
			len_r     <= 11'h000;
			add_crc_r <= 1'b1;
			add_pad_r <= 1'b1;
		end else begin
			pkt_end_r <= buf_done && last_seg;
			if (buf_done && last_seg) begin
				// tag is carried through untouched
				tag_r     <= pkt_b[`TXBCU_B_TAG_HI:`TXBCU_B_TAG_LO];
				len_r     <= pkt_b[`TXBCU_B_LEN_HI:`TXBCU_B_LEN_LO];
				len_err_r <= len_bad;
				add_pad_r <= !pkt_b[`TXBCU_B_PAD_DIS];
				add_crc_r <= !pkt_b[`TXBCU_B_CRC_DIS] ||
				             pkt_b[`TXBCU_B_PAD_DIS];
			end
		end
	end

	// sticky flags, a new event wins over a clear in the same cycle
	always @(posedge CORE_CLK) begin
		if (!RST_B) begin
			err_r    <= 1'b0;
			loaded_r <= 1'b0;
		end else begin
			// error is only recorded, the sequencing carries on
			if (len_bad || b_differs) begin
				err_r <= 1'b1;
			end else if (clr_err) begin
				err_r <= 1'b0;
			end
			if (buf_done && cmda_r[`TXBCU_A_LOAD_NOTIFY]) begin
				loaded_r <= 1'b1;
			end else if (clr_load) begin
				loaded_r <= 1'b0;
			end
		end
	end

	// control register; abort is a command and does not stay set
	always @(posedge CORE_CLK) begin
		if (!RST_B) begin
			ctrl_r <= `TXBCU_CTRL_RESET;
		end else if (access && PWRITE && hit_ctrl) begin
			ctrl_r <= {1'b0, PWDATA[`TXBCU_CTRL_ENABLE]};
		end
	end

	// read data captured in the setup cycle, shown in the access cycle
	always @(posedge CORE_CLK) begin
		if (!RST_B) begin
			prdata_r <= 32'h00000000;
		end else if (setup && !PWRITE) begin
			if (hit_sts) begin
				prdata_r <= {30'h0, loaded_r, err_r};
			end else if (hit_ctrl) begin
				prdata_r <= {30'h0, ctrl_r};
			end else if (hit_info) begin
				prdata_r <= {pkt_cmdb_r[`TXBCU_B_TAG_HI:`TXBCU_B_TAG_LO],
				             pkt_open_r, out_valid_r, state_r, acc_r};
			end else begin
				prdata_r <= 32'h00000000;
			end
		end
	end

	assign MAC_DATA            = out_data_r;
	assign MAC_BYTE_EN         = out_be_r;
	assign MAC_LAST            = out_last_r;
	assign MAC_VALID           = out_valid_r;
	assign MAC_PKT_END         = pkt_end_r;
	assign MAC_TAG             = tag_r;
	assign MAC_LEN             = len_r;
	assign MAC_ADD_CRC         = add_crc_r;
	assign MAC_ADD_PAD         = add_pad_r;
	assign MAC_LEN_ERR         = len_err_r;
	assign TRANSMIT_ERROR_FLAG = err_r;
	assign BUFFER_LOADED_FLAG  = loaded_r;

endmodule

`default_nettype wire

/* verif/txbcu_top_props.sv */
// concurrent checks on the ports of the transmit buffer command unpacker
`timescale 1ns/1ps
`default_nettype none
module txbcu_top_props (
	input wire logic        CORE_CLK,
	input wire logic        RST_B,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic        PREADY,
	input wire logic [31:0] MAC_DATA,
	input wire logic [3:0]  MAC_BYTE_EN,
	input wire logic        MAC_VALID,
	input wire logic        MAC_READY,
	input wire logic        MAC_PKT_END,
	input wire logic [15:0] MAC_TAG,
	input wire logic        MAC_ADD_CRC,
	input wire logic        MAC_ADD_PAD,
	input wire logic        MAC_LEN_ERR,
	input wire logic        TRANSMIT_ERROR_FLAG
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	// status write that may clear the sticky flags
	wire status_wr = PSEL && PENABLE && PWRITE && PADDR == 8'h04;
	// a word offered to the mac but not taken yet
	sequence s_held;
		MAC_VALID && !MAC_READY;
	endsequence
	// packet close with a length mismatch reported
	sequence s_bad_close;
		MAC_PKT_END && MAC_LEN_ERR;
	endsequence
	valid_hold_a: assert property (s_held |=> MAC_VALID && $stable(MAC_DATA) && $stable(MAC_BYTE_EN))
		else $error("mac word changed while stalled");
	lane_ok_a: assert property (MAC_VALID |-> MAC_BYTE_EN inside {4'h1, 4'h3, 4'h7, 4'hF,
		4'h2, 4'h6, 4'hE, 4'h4, 4'hC, 4'h8}) else $error("byte lanes not contiguous");
	end_pulse_a: assert property (MAC_PKT_END |=> !MAC_PKT_END)
		else $error("packet end longer than one cycle");
	crc_force_a: assert property (!MAC_ADD_PAD |-> MAC_ADD_CRC)
		else $error("checksum dropped while padding disabled");
	len_err_a: assert property (s_bad_close |-> ##[0:2] TRANSMIT_ERROR_FLAG)
		else $error("length mismatch without error flag");
	err_sticky_a: assert property (TRANSMIT_ERROR_FLAG && !status_wr |=> TRANSMIT_ERROR_FLAG)
		else $error("error flag dropped without clear");
	stall_cause_a: assert property (!PREADY |-> s_held)
		else $error("bus stalled without mac back pressure");
	tag_hold_a: assert property (!MAC_PKT_END |-> $stable(MAC_TAG))
		else $error("tag changed outside packet end");
endmodule
bind txbcu_top txbcu_top_props props_u (
	.CORE_CLK(CORE_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PREADY(PREADY), .MAC_DATA(MAC_DATA), .MAC_BYTE_EN(MAC_BYTE_EN),
	.MAC_VALID(MAC_VALID), .MAC_READY(MAC_READY), .MAC_PKT_END(MAC_PKT_END), .MAC_TAG(MAC_TAG),
	.MAC_ADD_CRC(MAC_ADD_CRC), .MAC_ADD_PAD(MAC_ADD_PAD), .MAC_LEN_ERR(MAC_LEN_ERR),
	.TRANSMIT_ERROR_FLAG(TRANSMIT_ERROR_FLAG));
`default_nettype wire

/* verif/txbcu_host_model.sv */
// apb host model issuing single transfers to the unpacker
`timescale 1ns/1ps
`default_nettype none
module txbcu_host_model (
	input  wire logic        CORE_CLK,
	output var  logic        PSEL,
	output var  logic        PENABLE,
	output var  logic        PWRITE,
	output var  logic [7:0]  PADDR,
	output var  logic [31:0] PWDATA,
	input  wire logic [31:0] PRDATA,
	input  wire logic        PREADY,
	input  wire logic        PSLVERR
);
	// bus idle from time zero
	initial begin
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h00;
		PWDATA = 32'h0;
	end
	// setup, access held until ready is seen at a rising edge, answer taken there, then release
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CORE_CLK);
		PENABLE <= 1'b1;
		@(posedge CORE_CLK);
		while (!PREADY) @(posedge CORE_CLK);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CORE_CLK);
	endtask
endmodule
`default_nettype wire

/* verif/txbcu_top_tb_top.sv */
// self-checking bench for the transmit buffer command unpacker
`timescale 1ns/1ps
`default_nettype none
module txbcu_top_tb_top;
	logic        CORE_CLK = 1'b0;
	logic        RST_B = 1'b0;
	logic        MAC_READY = 1'b0;
	wire         PSEL, PENABLE, PWRITE, PREADY, PSLVERR, MAC_LAST, MAC_VALID, MAC_PKT_END;
	wire         MAC_ADD_CRC, MAC_ADD_PAD, MAC_LEN_ERR, TRANSMIT_ERROR_FLAG, BUFFER_LOADED_FLAG;
	wire  [7:0]  PADDR;
	wire  [31:0] PWDATA, PRDATA, MAC_DATA;
	wire  [3:0]  MAC_BYTE_EN;
	wire  [15:0] MAC_TAG;
	wire  [10:0] MAC_LEN;
	logic [31:0] rs = 32'h000165F7, ms = 32'h000165F7, rd;
	logic        er;
	logic [36:0] exp_w[$];
	logic [29:0] exp_p[$];
	int          n_mismatch = 0, n_compared = 0, cyc = 0;
	txbcu_top dut_u (
		.CORE_CLK(CORE_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.MAC_DATA(MAC_DATA), .MAC_BYTE_EN(MAC_BYTE_EN), .MAC_LAST(MAC_LAST),
		.MAC_VALID(MAC_VALID), .MAC_READY(MAC_READY), .MAC_PKT_END(MAC_PKT_END),
		.MAC_TAG(MAC_TAG), .MAC_LEN(MAC_LEN), .MAC_ADD_CRC(MAC_ADD_CRC),
		.MAC_ADD_PAD(MAC_ADD_PAD), .MAC_LEN_ERR(MAC_LEN_ERR),
		.TRANSMIT_ERROR_FLAG(TRANSMIT_ERROR_FLAG), .BUFFER_LOADED_FLAG(BUFFER_LOADED_FLAG));
	txbcu_host_model host_u (
		.CORE_CLK(CORE_CLK), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
	always #10 CORE_CLK = ~CORE_CLK;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (e !== g) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
		host_u.xfer(1'b0, a, 32'h0, rd, er);
		chk("prdata", e, rd);
		chk("pslverr", {31'h0, ee}, {31'h0, er});
	endtask
	// command words, then body words with random filler; notes each forwarded word
	task automatic send_buf(input logic [10:0] sz, input logic [4:0] off, input logic [1:0] al,
			input logic fs, input logic ls, input logic nt, input logic [31:0] b);
		int ab, tot;
		logic [3:0] be;
		ab = (al == 2'h0) ? 4 : ((al == 2'h1) ? 16 : 32);
		tot = (off + sz + ab - 1) / ab * ab / 4;
		host_u.xfer(1'b1, 8'h00, {nt, 5'h0, al, 3'h0, off, 2'h0, fs, ls, 1'b0, sz}, rd, er);
		host_u.xfer(1'b1, 8'h00, b, rd, er);
		for (int i = 0; i < tot; i++) begin
			rs = xs(rs);
			for (int j = 0; j < 4; j++) be[j] = (4 * i + j >= off) && (4 * i + j < off + sz);
			if (be != 4'h0) exp_w.push_back({ls && (4 * i + 4 >= off + sz), be, rs});
			host_u.xfer(1'b1, 8'h00, rs, rd, er);
		end
	endtask
	// one packet of nb buffers; bl spoils the length, bb spoils the second word of buffer 1
	task automatic pkt(input int nb, input logic bl, input logic bb, input logic nt);
		logic [10:0] sz[4];
		logic [10:0] sum;
		logic [31:0] b;
		sum = 11'h0;
		rs = xs(rs);
		for (int k = 0; k < nb; k++) begin
			sz[k] = (nb == 1) ? 11'(rs[5:0]) : 11'(4 + rs[k * 4 +: 4]);
			sum += sz[k];
		end
		rs = xs(rs);
		b = {rs[31:16], 2'h0, rs[1:0], 1'b0, sum + 11'(bl)};
		exp_p.push_back({bl, !rs[0], !rs[1] | rs[0], b[10:0], rs[31:16]});
		for (int k = 0; k < nb; k++) begin
			rs = xs(rs);
			send_buf(sz[k], rs[4:0], rs[9] ? 2'h2 : {1'b0, rs[8]}, k == 0, k == nb - 1, nt,
				b ^ {15'h0, bb && k == 1, 16'h0});
		end
	endtask
	task automatic drain();
		for (int i = 0; i < 300 && exp_w.size() + exp_p.size() > 0; i++) @(posedge CORE_CLK);
		repeat (3) @(posedge CORE_CLK);
		chk("left_in_queue", 32'h0, 32'(exp_w.size() + exp_p.size()));
	endtask
	// mac sink with random stalls; compares each taken word and each packet close
	always @(posedge CORE_CLK) begin
		logic [36:0] e;
		logic [31:0] m;
		cyc <= cyc + 1;
		ms = xs(ms);
		MAC_READY <= ms[3] | ms[4];
		if (MAC_VALID && MAC_READY) begin
			chk("word_expected", 32'h1, 32'(exp_w.size() != 0));
			if (exp_w.size() != 0) e = exp_w.pop_front();
			m = {{8{e[35]}}, {8{e[34]}}, {8{e[33]}}, {8{e[32]}}};
			chk("mac_data", e[31:0] & m, MAC_DATA & m);
			chk("mac_byte_en", {28'h0, e[35:32]}, {28'h0, MAC_BYTE_EN});
			chk("mac_last", {31'h0, e[36]}, {31'h0, MAC_LAST});
		end
		if (MAC_PKT_END) begin
			chk("pkt_expected", 32'h1, 32'(exp_p.size() != 0));
			if (exp_p.size() != 0) e = {7'h0, exp_p.pop_front()};
			chk("pkt_info", e[31:0], {2'h0, MAC_LEN_ERR, MAC_ADD_PAD, MAC_ADD_CRC, MAC_LEN, MAC_TAG});
		end
		if (cyc == 40000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (16) @(posedge CORE_CLK);
		RST_B <= 1'b1;
		@(posedge CORE_CLK);
		rdchk(8'h08, 32'h1, 1'b0);
		rdchk(8'h04, 32'h0, 1'b0);
		rdchk(8'h10, 32'h0, 1'b1);
		rdchk(8'h00, 32'h0, 1'b1);
		for (int i = 0; i < 16; i++) pkt(1 + i % 4, 1'b0, 1'b0, i == 5);
		drain();
		chk("loaded_flag", 32'h1, {31'h0, BUFFER_LOADED_FLAG});
		rdchk(8'h04, 32'h2, 1'b0);
		host_u.xfer(1'b1, 8'h04, 32'h3, rd, er);
		pkt(2, 1'b1, 1'b0, 1'b0);
		drain();
		rdchk(8'h04, 32'h1, 1'b0);
		chk("error_flag", 32'h1, {31'h0, TRANSMIT_ERROR_FLAG});
		host_u.xfer(1'b1, 8'h04, 32'h1, rd, er);
		pkt(3, 1'b0, 1'b1, 1'b0);
		drain();
		rdchk(8'h04, 32'h1, 1'b0);
		host_u.xfer(1'b1, 8'h08, 32'h0, rd, er);
		host_u.xfer(1'b1, 8'h00, 32'h0, rd, er);
		chk("pslverr_disabled", 32'h1, {31'h0, er});
		host_u.xfer(1'b1, 8'h08, 32'h1, rd, er);
		host_u.xfer(1'b1, 8'h00, 32'h0, rd, er);
		host_u.xfer(1'b1, 8'h08, 32'h3, rd, er);
		rdchk(8'h08, 32'h1, 1'b0);
		pkt(2, 1'b0, 1'b0, 1'b0);
		drain();
		rdchk(8'h04, 32'h1, 1'b0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
